// ### hdl/scpl_pkg.sv
package scpl_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NPIN  = 8;
    localparam int NCOND = 8;
    localparam int AW    = 6;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CFG0   = 6'h00; // words 0..7, stride 4
    localparam logic [AW-1:0] OFS_CFGTOP = 6'h1c;
    localparam logic [AW-1:0] OFS_SETSEL = 6'h20;
    localparam logic [AW-1:0] OFS_PINS   = 6'h24;
    localparam logic [AW-1:0] OFS_SAFE   = 6'h28;
    localparam logic [AW-1:0] OFS_CHG    = 6'h2c;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_RST    = 16'h00ff; // and: all, or: none
    localparam logic [7:0]  SETSEL_RST = 8'h00;    // all pins on safety set
    localparam int          FULL_BIT   = 5;        // status word flag
    localparam int          STRB_LO    = 0;
    localparam int          STRB_HI    = 1;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // condition carriers, msb first = mask bit 7
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cell_over;
        logic cell_under;
        logic cell_diff;
        logic pack_over;
        logic temp_over;
        logic temp_under;
        logic chg_cur_over;
        logic dis_cur_over;
    } scpl_safety_t;

    typedef struct packed {
        logic cell_over;
        logic term_alarm;
        logic soc_over;
        logic temp_over;
        logic precharge;
        logic input_pin;
        logic eoc_over;
    } scpl_charge_t;

    // ----------------------------------------------------------------
    // combiner terms
    // ----------------------------------------------------------------
    function automatic logic scpl_and_term(input logic [15:0] w,
                                           input logic [7:0]  c);
        return &(~w[7:0] | c);
    endfunction

    function automatic logic scpl_or_term(input logic [15:0] w,
                                          input logic [7:0]  c);
        return |(w[15:8] & c);
    endfunction

    // word address of a byte address
    function automatic logic [AW-1:0] scpl_word(input logic [AW-1:0] a);
        return {a[AW-1:2], 2'h0};
    endfunction
endpackage

// ### hdl/scpl_top.sv
`timescale 1ns/10ps
module scpl_top
    import scpl_pkg::*;
(
    input  wire logic              aclk,       // system clock
    input  wire logic              aresetn,    // sync reset, low
    input  wire logic [AW-1:0]     awaddr,     // write address
    input  wire logic              awvalid,    // write address valid
    output logic                   awready,    // write address ready
    input  wire logic [31:0]       wdata,      // write data
    input  wire logic [3:0]        wstrb,      // write byte strobes
    input  wire logic              wvalid,     // write data valid
    output logic                   wready,     // write data ready
    output logic [1:0]             bresp,      // write response
    output logic                   bvalid,     // write response valid
    input  wire logic              bready,     // write response ready
    input  wire logic [AW-1:0]     araddr,     // read address
    input  wire logic              arvalid,    // read address valid
    output logic                   arready,    // read address ready
    output logic [31:0]            rdata,      // read data
    output logic [1:0]             rresp,      // read response
    output logic                   rvalid,     // read data valid
    input  wire logic              rready,     // read data ready
    input  wire scpl_safety_t      safety_cond, // safety conditions
    input  wire scpl_charge_t      charge_cond, // charge conditions
    input  wire logic [15:0]       battery_status, // status word
    output logic [NPIN-1:0]        pin_out     // configured output pins
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NPIN-1:0][15:0] cfg;
        logic [NPIN-1:0]       set_sel;  // 1 = charge set
        logic [NPIN-1:0]       pins;
        logic [AW-1:0]         aw_addr;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  aw_got;
        logic                  w_got;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } scpl_state_t;

    // word index bits of a byte address; the two low bits are ignored
    localparam int          IX_LO         = 2;
    localparam int          IX_HI         = 4;
    // lone-condition words: an all-ones and byte only adds to the or bit
    localparam logic [15:0] CFG_FULL_ONLY = 16'h20ff;
    localparam logic [15:0] CFG_CELL_ONLY = 16'h80ff;
    localparam int          PIN_FULL      = 0;
    localparam int          PIN_CELL      = 5;

    localparam scpl_state_t ST_RST = '{
        cfg: {NPIN{CFG_RST}}, set_sel: SETSEL_RST,
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        bresp: RESP_OKAY, rresp: RESP_OKAY, default: '0};

    scpl_state_t                     st_q;
    scpl_state_t                     st_d;
    logic [NCOND-1:0]                safe_vec;
    logic [NCOND-1:0]                chg_vec;
    logic [NPIN-1:0][NCOND-1:0]      cond_sel;

    // ----------------------------------------------------------------
    // condition sets
    // ----------------------------------------------------------------
    // packed struct order puts each condition on its mask bit
    assign safe_vec = safety_cond;
    // fully charged comes from the status word, not a separate pin
    assign chg_vec = {charge_cond.cell_over,
                      charge_cond.term_alarm,
                      battery_status[FULL_BIT],
                      charge_cond.soc_over, charge_cond.temp_over,
                      charge_cond.precharge,
                      charge_cond.input_pin, charge_cond.eoc_over};

    // per-pin choice of condition set
    for (genvar p = 0; p < NPIN; p++) begin : g_sel
        assign cond_sel[p] = st_q.set_sel[p] ? chg_vec : safe_vec;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic            aw_ok;
        logic            w_ok;
        logic [AW-1:0]   wa;
        logic [31:0]     wd;
        logic [3:0]      ws;
        logic [AW-1:0]   ra;
        logic [2:0]      ix;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        wa    = '0;
        wd    = '0;
        ws    = '0;
        ra    = '0;
        ix    = '0;
        st_d  = st_q;

        // pins follow the inputs of this cycle, one flop of latency
        for (int p = 0; p < NPIN; p++) begin
            st_d.pins[p] = scpl_and_term(st_q.cfg[p], cond_sel[p])
                         | scpl_or_term(st_q.cfg[p], cond_sel[p]);
        end

        // write channels accepted in either order
        aw_ok = st_q.aw_got | (awvalid & st_q.awready);
        w_ok  = st_q.w_got  | (wvalid  & st_q.wready);
        wa    = st_q.aw_got ? st_q.aw_addr : awaddr;
        wd    = st_q.w_got  ? st_q.w_data  : wdata;
        ws    = st_q.w_got  ? st_q.w_strb  : wstrb;
        if (awvalid && st_q.awready) begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = awaddr;
            st_d.awready = 1'b0;
        end
        if (wvalid && st_q.wready) begin
            st_d.w_got  = 1'b1;
            st_d.w_data = wdata;
            st_d.w_strb = wstrb;
            st_d.wready = 1'b0;
        end
        if (aw_ok && w_ok && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = RESP_OKAY;
            ix = wa[IX_HI:IX_LO];
            if (scpl_word(wa) <= OFS_CFGTOP) begin
                // byte lanes split the and byte from the or byte
                if (ws[STRB_LO]) st_d.cfg[ix][7:0]  = wd[7:0];
                if (ws[STRB_HI]) st_d.cfg[ix][15:8] = wd[15:8];
            end else if (scpl_word(wa) == OFS_SETSEL) begin
                if (ws[STRB_LO]) st_d.set_sel = wd[7:0];
            end else if (scpl_word(wa) == OFS_PINS ||
                         scpl_word(wa) == OFS_SAFE ||
                         scpl_word(wa) == OFS_CHG) begin
                st_d.bresp = RESP_OKAY; // read-only, write ignored
            end else begin
                st_d.bresp = RESP_SLVERR;
            end
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end

        // read: one request at a time, answer on the next edge
        if (arvalid && st_q.arready) begin
            ra = scpl_word(araddr);
            ix = araddr[IX_HI:IX_LO];
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rresp   = RESP_OKAY;
            st_d.rdata   = '0;
            if (ra <= OFS_CFGTOP) begin
                st_d.rdata[15:0] = st_q.cfg[ix];
            end else if (ra == OFS_SETSEL) begin
                st_d.rdata[7:0] = st_q.set_sel;
            end else if (ra == OFS_PINS) begin
                st_d.rdata[7:0] = st_q.pins;
            end else if (ra == OFS_SAFE) begin
                st_d.rdata[7:0] = safe_vec;
            end else if (ra == OFS_CHG) begin
                st_d.rdata[7:0] = chg_vec;
            end else begin
                st_d.rresp = RESP_SLVERR;
            end
        end
        if (st_q.rvalid && rready) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // all outputs straight from the state flops
    assign awready = st_q.awready;
    assign wready  = st_q.wready;
    assign bvalid  = st_q.bvalid;
    assign bresp   = st_q.bresp;
    assign arready = st_q.arready;
    assign rvalid  = st_q.rvalid;
    assign rdata   = st_q.rdata;
    assign rresp   = st_q.rresp;
    assign pin_out = st_q.pins;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NPIN; p++) begin : g_chk
        a_and_all_met: assert property (@(posedge aclk)
            disable iff (!aresetn)
            (&(~st_q.cfg[p][7:0] | cond_sel[p])) |=> pin_out[p])
            else $error("and term met but pin low");
        a_or_any_met: assert property (@(posedge aclk)
            disable iff (!aresetn)
            (|(st_q.cfg[p][15:8] & cond_sel[p])) |=> pin_out[p])
            else $error("or term met but pin low");
        a_pin_inactive: assert property (@(posedge aclk)
            disable iff (!aresetn)
            (!(&(~st_q.cfg[p][7:0] | cond_sel[p])) &&
             !(|(st_q.cfg[p][15:8] & cond_sel[p]))) |=> !pin_out[p])
            else $error("pin active with no term true");
    end

    a_full_flag_pin: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (st_q.set_sel[PIN_FULL] && st_q.cfg[PIN_FULL] == CFG_FULL_ONLY)
        |=> pin_out[PIN_FULL] == $past(battery_status[FULL_BIT]))
        else $error("fully charged flag not on pin 0");

    a_safety_cell: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (!st_q.set_sel[PIN_CELL] && st_q.cfg[PIN_CELL] == CFG_CELL_ONLY)
        |=> pin_out[PIN_CELL] == $past(safety_cond.cell_over))
        else $error("cell over not routed to pin 5");

    sequence s_wr_both;
        (st_q.aw_got || (awvalid && awready)) &&
        (st_q.w_got || (wvalid && wready)) && !bvalid;
    endsequence

    a_wr_answer: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_wr_both |=> bvalid)
        else $error("write not answered");

    a_b_hold: assert property (@(posedge aclk)
        disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bvalid dropped early");

    a_rd_answer: assert property (@(posedge aclk)
        disable iff (!aresetn)
        arvalid && arready && scpl_word(araddr) == OFS_PINS
        |=> rvalid && rdata[7:0] == $past(pin_out))
        else $error("pin status read wrong");

    a_r_hold: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rvalid dropped early");

    a_ar_block: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rvalid |-> !arready)
        else $error("address taken while read pending");

    a_aw_block: assert property (@(posedge aclk)
        disable iff (!aresetn)
        bvalid |-> !awready && !wready)
        else $error("write taken while response pending");

    a_aw_idle: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !bvalid && !st_q.aw_got |-> awready)
        else $error("write address refused while idle");

    a_rd_unmapped: assert property (@(posedge aclk)
        disable iff (!aresetn)
        arvalid && arready && scpl_word(araddr) > OFS_CHG
        |=> rvalid && rresp == RESP_SLVERR && rdata == '0)
        else $error("unmapped read not refused");

    // reset must clear pins and both answers whatever state it met
    a_pin_reset: assert property (@(posedge aclk)
        !aresetn |=> pin_out == '0 && !bvalid && !rvalid)
        else $error("outputs not cleared by reset");
endmodule

// ### tb/scpl_pin_sink.sv
`timescale 1ns/10ps
module scpl_pin_sink
    import scpl_pkg::*;
(
    input  wire logic            aclk,    // system clock
    input  wire logic            aresetn, // sync reset, low
    input  wire logic [NPIN-1:0] pin_lvl, // pin levels from block
    output logic      [NPIN-1:0] trip_q   // pins ever seen active
);
    // protection latch: a trip holds until reset, like a fuse driver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_q <= '0;
        end else begin
            trip_q <= trip_q | pin_lvl;
        end
    end
endmodule

// ### tb/safety_condition_pin_logic_tb_top.sv
`timescale 1ns/10ps
module safety_condition_pin_logic_tb_top
    import scpl_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [AW-1:0]   awaddr, araddr;
    logic [31:0]     wdata, rdata;
    logic [3:0]      wstrb;
    logic [1:0]      bresp, rresp;
    scpl_safety_t    safety_i;
    scpl_charge_t    charge_i;
    logic [15:0]     battery_status, lf, b;
    logic [NPIN-1:0] pin_out, trip_q, exp_trip;
    logic [15:0]     cfg [NPIN];
    logic [7:0]      sel, s, cx;
    logic [6:0]      c;
    logic [7:0]      tv [4] = '{8'h88, 8'h80, 8'h10, 8'hff};
    int              fail_count, total_checks, cyc, i, p;

    scpl_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .safety_cond(safety_i), .charge_cond(charge_i),
        .battery_status(battery_status), .pin_out(pin_out));
    scpl_pin_sink u_sink (.aclk(aclk), .aresetn(aresetn), .pin_lvl(pin_out),
        .trip_q(trip_q));

    // -----------------------------------------------------------------
    // clock, hang guard and helpers
    // -----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ceiling well above the roughly 630 cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected pin levels from the mirrored words and select bits
    function automatic logic [7:0] pexp(input logic [7:0] sv, cv);
        logic [7:0] r, k;
        for (int n = 0; n < NPIN; n++) begin
            k = sel[n] ? cv : sv;
            r[n] = (&(~cfg[n][7:0] | k)) | (|(cfg[n][15:8] & k));
        end
        return r;
    endfunction
    task automatic chk32(input logic [31:0] g, e, input string m);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic chk_pin(input logic [7:0] g, e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t pins got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // bus master; the extra edge at the end keeps strobes from toggling
    // twice in one time step on back-to-back calls
    // -----------------------------------------------------------------
    task automatic axw(input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] st, input logic [1:0] er);
        logic ad, wd, bd;
        ad = 1'b0;
        wd = 1'b0;
        bd = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bd) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                bd = 1'b1;
                chk32({30'h0, bresp}, {30'h0, er}, "bresp");
                bready <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask
    task automatic axr(input logic [5:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        logic ad, rd;
        ad = 1'b0;
        rd = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rd) begin
            @(posedge aclk);
            if (!ad && arready) begin
                ad = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                rd = 1'b1;
                chk32(rdata, ed, "rdata");
                chk32({30'h0, rresp}, {30'h0, er}, "rresp");
                rready <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask
    // inputs settle over two edges: the first registers the pins, the check follows the second
    task automatic cond(input logic [7:0] sv, input logic [6:0] cv,
                        input logic [15:0] bs);
        logic [7:0] e;
        safety_i <= sv;
        charge_i <= cv;
        battery_status <= bs;
        e = pexp(sv, {cv[6:5], bs[FULL_BIT], cv[4:0]});
        exp_trip |= e;
        repeat (2) @(posedge aclk);
        chk_pin(pin_out, e);
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {safety_i, charge_i, battery_status, sel, exp_trip} = '0;
        {fail_count, total_checks, cyc} = '0;
        lf = 16'h0061;
        for (p = 0; p < NPIN; p++) cfg[p] = CFG_RST;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (p = 0; p < NPIN; p++) axr(6'(4 * p), {16'h0, CFG_RST}, RESP_OKAY);
        axr(OFS_SETSEL, 32'h0, RESP_OKAY);
        axw(6'h30, 32'h1234, 4'hf, RESP_SLVERR);
        axr(6'h30, 32'h0, RESP_SLVERR);
        axw(OFS_PINS, 32'hff, 4'hf, RESP_OKAY);
        axr(OFS_PINS, 32'h0, RESP_OKAY);
        axw(OFS_CFG0, 32'habcd, 4'h1, RESP_OKAY);
        cfg[0] = 16'h00cd;
        axr(OFS_CFG0, 32'h00cd, RESP_OKAY);
        axw(6'h14, 32'h1088, 4'h3, RESP_OKAY);
        cfg[5] = 16'h1088;
        axw(6'h18, 32'h00ff, 4'h3, RESP_OKAY);
        for (i = 0; i < 4; i++) cond(tv[i], 7'h0, 16'h0);
        for (i = 0; i < 48; i++) begin
            if (i % 8 == 0) begin
                for (p = 0; p < NPIN; p++) begin
                    lf = nxt(lf);
                    cfg[p] = lf;
                    axw(6'(4 * p), {16'h0, lf}, 4'h3, RESP_OKAY);
                end
                lf = nxt(lf);
                sel = lf[7:0];
                axw(OFS_SETSEL, {24'h0, sel}, 4'h1, RESP_OKAY);
            end
            lf = nxt(lf);
            s = lf[7:0];
            c = lf[14:8];
            lf = nxt(lf);
            b = lf;
            cond(s, c, b);
            axr(OFS_SAFE, {24'h0, s}, RESP_OKAY);
            cx = {c[6:5], b[FULL_BIT], c[4:0]};
            axr(OFS_CHG, {24'h0, cx}, RESP_OKAY);
        end
        // lone conditions behind an all-ones and byte, one pin per set
        cfg[0] = 16'h20ff;
        cfg[5] = 16'h80ff;
        sel    = 8'h01;
        axw(OFS_CFG0, 32'h20ff, 4'h3, RESP_OKAY);
        axw(6'h14, 32'h80ff, 4'h3, RESP_OKAY);
        axw(OFS_SETSEL, 32'h01, 4'h1, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            b = '0;
            b[FULL_BIT] = i[1];
            cond({i[0], 7'h0}, 7'h0, b);
        end
        chk_pin(trip_q & exp_trip, exp_trip);
        results();
    end
endmodule
